// ### ddp_port.sv
/*
  Drive side of the disk controller: accepts channel functions,
  sends drive commands and write data on the outbound cable, samples
  the inbound cable and keeps the status and call reply registers.
  Assumes all inputs synchronous to clock and a slow read clock.
*/
// Notes on behaviour
// [RL1] Buffer B and A read parity errors set bits 10 and 9; read clears.
// [RL2] Dropped functions set bit 8; status read is never dropped.
// [RL3] Bits 7 and 6 sample inbound parity lines at each read clock fall.
// [RL4] Inbound data parity error sets bit 5; read clears.
// [RL5] Bad status line parity while ready sets bit 4; read clears.
// [RL6] Sampled error line sets bit 3; read clears.
// [RL7] Strobe, error and done together set bit 2; read clears.
// [RL8] Strobe and done without error set bit 1; read clears.
// [RL9] Bit 0 follows drive ready; reads leave it alone.
// [RL10] Done captures inbound data; status read returns then clears it.
// [RL11] Some functions load drive status with their start bus-out value.
// [RL12] An error at completion marks drive status as not valid.
// [RL13] Function second parcel held as call reply, sent on enabled call.
// [RL14] Write clock has even duty; outputs change on its rising edge.
// [RL15] Function strobe lasts exactly one write clock period.
// [RL16] Function code sent with odd parity under the strobe.
// [RL17] Bus-out data sent with odd parity under the strobe.
// [RL18] Drive supplies a 320 ns read clock, changing data on rise.
// [RL19] Drive pulses strobe, error and done for one read clock each.
// [RL20] Inbound parities checked only while drive ready is high.
// [RL21] Inbound data used only when strobe or done is high.
// [RL22] Read clock fall is three high samples then a low.
// [RL23] Write clock derived by division; strobes align to its rise.
// [RL24] Busy set by a pending function, cleared by done.
// [RL25] A set coinciding with the clearing read keeps the bit set.
`include "ddp_params.svh"

module ddp_port
  import ddp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Channel function request
  input wire logic func_valid,
  input wire logic [7:0] func_code,
  input wire logic [15:0] func_param,
  // Channel call
  input wire logic call_pulse,
  input wire logic int_enable,
  // Buffer side
  input wire logic buf_a_perr,
  input wire logic buf_b_perr,
  input wire logic wr_valid,
  input wire logic [15:0] wr_data,
  // Inbound cable
  input wire logic rclk,
  input wire logic in_strobe,
  input wire logic in_error,
  input wire logic in_done,
  input wire logic in_ready,
  input wire logic stat_par,
  input wire logic [15:0] bus_in,
  input wire logic bus_in_par,
  // Outbound cable
  output logic wclk,
  output logic fstrobe,
  output logic [3:0] fcode,
  output logic fpar,
  output logic [15:0] bus_out,
  output logic bus_out_par,
  // Responses
  output logic resp_valid,
  output logic [15:0] resp_drive,
  output logic [15:0] resp_ctrl,
  output logic call_valid,
  output logic [15:0] call_data,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic wr_taken
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] drive_code(input logic [7:0] f);
    logic [4:0] g;
    g = f[7:3];
    if (f == `DDP_F_RELEASE) drive_code = 4'hf;
    else if (f == `DDP_F_RELOPP) drive_code = 4'he;
    else if (f == `DDP_F_CLRFLT) drive_code = 4'hc;
    else if (f == `DDP_F_RESET) drive_code = 4'hb;
    else if (f == `DDP_F_CYL) drive_code = 4'h5;
    else if (f == `DDP_F_HEAD) drive_code = 4'h4;
    else if (g == `DDP_G_SELECT) drive_code = 4'h1;
    else if (g == `DDP_G_RTZ) drive_code = 4'hd;
    else if (g == `DDP_G_SELSTAT) drive_code = 4'h7;
    else if (g == `DDP_G_GENSTAT) drive_code = 4'h8;
    else if (g == `DDP_G_DIAG) drive_code = 4'h9;
    else if (g == `DDP_G_RD0 || g == `DDP_G_RD1) drive_code = 4'h2;
    else if (g == `DDP_G_WR0 || g == `DDP_G_WR1) drive_code = 4'h3;
    else if (g == `DDP_G_ECHOPAR) drive_code = 4'h0;
    else drive_code = `DDP_C_NONE;
  endfunction

  function automatic logic odd_par16(input logic [15:0] d);
    odd_par16 = ~^d;
  endfunction

  // ----------------------------------------------------------------
  // Write clock and read clock edge
  // ----------------------------------------------------------------
  logic wclk_load;
  logic rclk_fall;

  ddp_wclk_gen u_wclk (
    .clock(clock),
    .rst(rst),
    .wclk(wclk),
    .load(wclk_load)
  );

  ddp_rclk_edge u_redge (
    .clock(clock),
    .rst(rst),
    .rclk(rclk),
    .fall(rclk_fall)
  );

  // ----------------------------------------------------------------
  // Function decode
  // ----------------------------------------------------------------
  logic [4:0] grp;
  logic is_status;
  logic is_rw;
  logic is_wr;
  logic is_internal;
  logic is_disk;
  logic loads_bo;
  logic [3:0] dcode;

  always_comb begin
    grp = func_code[7:3];
    dcode = drive_code(func_code);
    is_status = (grp == `DDP_G_STATUS);
    is_wr = (grp == `DDP_G_WR0) || (grp == `DDP_G_WR1);
    is_rw = is_wr || (grp == `DDP_G_RD0) || (grp == `DDP_G_RD1);
    is_internal = (grp == `DDP_G_RDCHAN) || (grp == `DDP_G_ECHOBUF);
    is_disk = (dcode != `DDP_C_NONE);
    loads_bo = is_rw || (grp == `DDP_G_DIAG) || (grp == `DDP_G_ECHOPAR) ||
               (func_code == `DDP_F_CYL) || (func_code == `DDP_F_HEAD);
  end

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  ddp_port_state_t s_reg;
  ddp_port_state_t s_next;
  logic [15:0] set_bits;
  logic lost;
  logic accept;
  logic st_read;
  logic ev_done;
  logic ev_status;

  always_comb begin
    s_next = s_reg;
    set_bits = 16'h0000;
    s_next.resp_valid = 1'b0;
    s_next.call_valid = 1'b0;
    s_next.rd_valid = 1'b0;
    s_next.wr_taken = 1'b0;
    st_read = func_valid && is_status;
    lost = 1'b0;
    accept = 1'b0;
    // Function acceptance
    if (func_valid && is_disk) begin
      if (is_rw && s_reg.rw_pend) begin
        lost = 1'b1; // RL2
      end else if (s_reg.busy || s_reg.fn_pend) begin
        lost = 1'b1; // RL2
      end else begin
        accept = 1'b1;
      end
    end else if (func_valid && is_internal && s_reg.busy) begin
      lost = 1'b1; // RL2
    end
    if (accept) begin
      s_next.fn_pend = 1'b1;
      s_next.busy = 1'b1; // RL24
      s_next.fn_code = dcode;
      s_next.saved_bo = func_param;
      s_next.fn_loads_bo = loads_bo;
      s_next.call_reply = func_param; // RL13
      if (is_rw) begin
        s_next.rw_pend = 1'b1;
        s_next.rw_write = is_wr;
      end
    end
    // Channel call substitutes the held reply
    if (call_pulse && int_enable) begin
      s_next.call_valid = 1'b1; // RL13
      s_next.call_data = s_reg.call_reply;
    end
    // Outbound cycle, chosen just before each write clock rise
    if (wclk_load) begin
      if (s_reg.fn_pend) begin
        s_next.ocyc = DDP_OC_FUNC;
        s_next.fn_pend = 1'b0;
        s_next.done_loads_bo = s_reg.fn_loads_bo;
        s_next.fstrobe = 1'b1; // RL15
        s_next.fcode = s_reg.fn_code;
        s_next.fpar = ~^s_reg.fn_code; // RL16
        s_next.bus_out = s_reg.saved_bo;
        s_next.bus_out_par = odd_par16(s_reg.saved_bo); // RL17
      end else if (s_reg.rw_pend && s_reg.rw_write && s_reg.busy && wr_valid) begin
        s_next.ocyc = DDP_OC_DATA;
        s_next.fstrobe = 1'b1; // RL15
        s_next.bus_out = wr_data;
        s_next.bus_out_par = odd_par16(wr_data); // RL17
        s_next.wr_taken = 1'b1;
      end else begin
        s_next.ocyc = DDP_OC_IDLE;
        s_next.fstrobe = 1'b0; // RL23
      end
    end
    // Inbound cycle at the detected read clock fall
    ev_done = rclk_fall && in_done;
    ev_status = rclk_fall && in_strobe && !in_done;
    if (rclk_fall) begin
      s_next.flags[`DDP_B_BUSIN_PAR] = bus_in_par; // RL3
      s_next.flags[`DDP_B_STAT_PAR] = stat_par; // RL3
      if (in_ready && (in_strobe || in_done) && (^{bus_in, bus_in_par} == 1'b0)) begin
        set_bits[`DDP_B_BUSIN_PERR] = 1'b1; // RL4 RL20 RL21
      end
      if (in_ready && (^{in_strobe, in_error, in_done, in_ready, stat_par} == 1'b0)) begin
        set_bits[`DDP_B_STAT_PERR] = 1'b1; // RL5 RL20
      end
      set_bits[`DDP_B_DRV_ERR] = in_error; // RL6
      set_bits[`DDP_B_DRV_BUSY] = in_strobe && in_error && in_done; // RL7
      set_bits[`DDP_B_DS_AVAIL] = in_strobe && in_done && !in_error; // RL8
    end
    if (ev_status) begin
      if (s_reg.rw_pend && !s_reg.rw_write) begin
        s_next.rd_valid = 1'b1; // RL21
        s_next.rd_data = bus_in;
      end else begin
        s_next.drive_stat = bus_in; // RL21
      end
    end
    set_bits[`DDP_B_BUFB_PERR] = buf_b_perr; // RL1
    set_bits[`DDP_B_BUFA_PERR] = buf_a_perr; // RL1
    set_bits[`DDP_B_LOST] = lost; // RL2
    // Status read answers with the values held before the clear
    if (st_read) begin
      s_next.resp_valid = 1'b1;
      s_next.resp_drive = s_reg.drive_stat; // RL10
      s_next.resp_ctrl = s_reg.flags;
      s_next.drive_stat = 16'h0000; // RL10
      s_next.flags = s_next.flags & ~`DDP_CLR_ON_READ;
    end
    if (ev_done) begin
      // Error at done leaves bit 1 clear, flagging the capture as bad
      s_next.drive_stat = (s_reg.done_loads_bo && !in_error) ?
                          s_reg.saved_bo : bus_in; // RL10 RL11 RL12
      s_next.busy = 1'b0; // RL24
      s_next.rw_pend = 1'b0;
    end
    s_next.flags = s_next.flags | set_bits; // RL25
    s_next.flags[`DDP_B_DRV_READY] = in_ready; // RL9
    s_next.flags[15:11] = 5'h00;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.flags <= `DDP_FLAGS_RESET;
      s_reg.ocyc <= DDP_OC_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign fstrobe = s_reg.fstrobe;
  assign fcode = s_reg.fcode;
  assign fpar = s_reg.fpar;
  assign bus_out = s_reg.bus_out;
  assign bus_out_par = s_reg.bus_out_par;
  assign resp_valid = s_reg.resp_valid;
  assign resp_drive = s_reg.resp_drive;
  assign resp_ctrl = s_reg.resp_ctrl;
  assign call_valid = s_reg.call_valid;
  assign call_data = s_reg.call_data;
  assign rd_valid = s_reg.rd_valid;
  assign rd_data = s_reg.rd_data;
  assign wr_taken = s_reg.wr_taken;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  strobe_one_period_a: assert property ( // RL15
    $rose(fstrobe) |-> fstrobe [*2] ##1 (!fstrobe || wr_taken || $past(s_reg.fn_pend)))
    else $error("function strobe shorter than one write clock period");
  strobe_on_rise_a: assert property ( // RL14
    $rose(fstrobe) |-> $rose(wclk))
    else $error("function strobe not aligned to write clock rise");
  wclk_duty_a: assert property ( // RL14
    $rose(wclk) |=> $fell(wclk) ##1 $rose(wclk))
    else $error("write clock not even duty");
  func_par_a: assert property ( // RL16
    fstrobe && s_reg.ocyc == DDP_OC_FUNC |-> ^{fcode, fpar} == 1'b1)
    else $error("function code parity not odd");
  data_par_a: assert property ( // RL17
    fstrobe |-> ^{bus_out, bus_out_par} == 1'b1)
    else $error("bus-out parity not odd");
  lost_flag_a: assert property ( // RL2
    func_valid && is_rw && s_reg.rw_pend && !is_status |=> s_reg.flags[`DDP_B_LOST])
    else $error("dropped read or write did not set lost flag");
  err_flag_a: assert property ( // RL6
    rclk_fall && in_error |=> s_reg.flags[`DDP_B_DRV_ERR])
    else $error("sampled error did not set drive error flag");
  avail_flag_a: assert property ( // RL8
    rclk_fall && in_strobe && in_done && !in_error |=> s_reg.flags[`DDP_B_DS_AVAIL])
    else $error("status available not set");
  ready_mirror_a: assert property ( // RL9
    s_reg.flags[`DDP_B_DRV_READY] == $past(in_ready))
    else $error("drive ready bit does not follow input");
  busy_clear_a: assert property ( // RL24
    rclk_fall && in_done |=> !s_reg.busy)
    else $error("busy not cleared by done");
  read_clears_a: assert property ( // RL10
    func_valid && is_status && !rclk_fall |=> resp_valid && s_reg.drive_stat == 16'h0000)
    else $error("status read did not return and clear drive status");
  call_reply_a: assert property ( // RL13
    call_pulse && int_enable |=> call_valid && call_data == $past(s_reg.call_reply))
    else $error("call reply not substituted");

  func_sent_c: cover property ($rose(fstrobe) && s_reg.ocyc == DDP_OC_FUNC);
  data_sent_c: cover property (wr_taken);
  done_seen_c: cover property (rclk_fall && in_done ##[1:400] resp_valid);
  lost_seen_c: cover property (lost);

endmodule

// ### ddp_params.svh
/*
  Constants of the drive port: status bit positions, function code
  groups, outbound drive codes and link timing counts.
  Assumes a 25 MHz module clock; included by name, definitions only.
*/
`ifndef DDP_PARAMS_SVH
`define DDP_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DDP_CLK_PERIOD_NS 40
`define DDP_WCLK_PERIOD_NS 80
`define DDP_WCLK_HALF_CYC ((`DDP_WCLK_PERIOD_NS / 2) / `DDP_CLK_PERIOD_NS)
`define DDP_RCLK_HIGH_SAMPLES 3

// ----------------------------------------------------------------
// Controller condition flag positions
// ----------------------------------------------------------------
`define DDP_B_BUFB_PERR 10
`define DDP_B_BUFA_PERR 9
`define DDP_B_LOST 8
`define DDP_B_BUSIN_PAR 7
`define DDP_B_STAT_PAR 6
`define DDP_B_BUSIN_PERR 5
`define DDP_B_STAT_PERR 4
`define DDP_B_DRV_ERR 3
`define DDP_B_DRV_BUSY 2
`define DDP_B_DS_AVAIL 1
`define DDP_B_DRV_READY 0
`define DDP_FLAGS_RESET 16'h0000
`define DDP_CLR_ON_READ 16'h073e

// ----------------------------------------------------------------
// Channel function groups (code bits 7:3) and drive codes
// ----------------------------------------------------------------
`define DDP_G_SELECT 5'h01
`define DDP_G_RTZ 5'h03
`define DDP_G_SELSTAT 5'h04
`define DDP_G_GENSTAT 5'h05
`define DDP_G_STATUS 5'h06
`define DDP_G_DIAG 5'h07
`define DDP_G_CYL 5'h08
`define DDP_G_RD0 5'h10
`define DDP_G_RD1 5'h11
`define DDP_G_RDCHAN 5'h15
`define DDP_G_WR0 5'h18
`define DDP_G_WR1 5'h19
`define DDP_G_ECHOBUF 5'h1e
`define DDP_G_ECHOPAR 5'h1f
`define DDP_F_RELEASE 8'h00
`define DDP_F_RELOPP 8'h01
`define DDP_F_CLRFLT 8'h10
`define DDP_F_RESET 8'h11
`define DDP_F_CYL 8'h40
`define DDP_F_HEAD 8'h41
`define DDP_C_NONE 4'h6

`endif

// ### ddp_pkg.sv
/*
  Types of the drive port: outbound cycle kinds and the packed state
  of each module. Assumes ddp_params.svh is not needed here.
*/
package ddp_pkg;

  typedef enum logic [1:0] {
    DDP_OC_IDLE = 2'b00,
    DDP_OC_FUNC = 2'b01,
    DDP_OC_DATA = 2'b10
  } ddp_ocyc_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic wclk;
    logic load;
  } ddp_wclk_state_t;

  typedef struct packed {
    logic [2:0] hist;
    logic fall;
  } ddp_edge_state_t;

  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] drive_stat;
    logic [15:0] call_reply;
    logic [15:0] saved_bo;
    logic busy;
    logic rw_pend;
    logic rw_write;
    logic fn_pend;
    logic fn_loads_bo;
    logic done_loads_bo;
    logic [3:0] fn_code;
    ddp_ocyc_t ocyc;
    logic fstrobe;
    logic [3:0] fcode;
    logic fpar;
    logic [15:0] bus_out;
    logic bus_out_par;
    logic resp_valid;
    logic [15:0] resp_drive;
    logic [15:0] resp_ctrl;
    logic call_valid;
    logic [15:0] call_data;
    logic rd_valid;
    logic [15:0] rd_data;
    logic wr_taken;
  } ddp_port_state_t;

endpackage

// ### ddp_wclk_gen.sv
/*
  Outbound write clock divider with a load strobe for the cycle
  before each rising edge. Assumes one synchronous module clock.
*/
`include "ddp_params.svh"

module ddp_wclk_gen
  import ddp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Write clock and load strobe
  output logic wclk,
  output logic load
);

  localparam logic [3:0] HALF_LAST = 4'(`DDP_WCLK_HALF_CYC - 1);

  ddp_wclk_state_t s_reg;
  ddp_wclk_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (s_reg.cnt == HALF_LAST) begin
      s_next.cnt = 4'h0;
      s_next.wclk = ~s_reg.wclk; // RL14 RL23
    end else begin
      s_next.cnt = s_reg.cnt + 4'h1;
    end
    // High in the last cycle before wclk rises
    s_next.load = (s_next.cnt == HALF_LAST) && !s_next.wclk; // RL23
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '{cnt: 4'h0, wclk: 1'b0, load: (HALF_LAST == 4'h0)};
    end else begin
      s_reg <= s_next;
    end
  end

  assign wclk = s_reg.wclk;
  assign load = s_reg.load;

endmodule

// ### ddp_rclk_edge.sv
/*
  Falling edge detector for the drive read clock: a run of high
  samples followed by a low one. Assumes rclk synchronous to clock.
*/
`include "ddp_params.svh"

module ddp_rclk_edge
  import ddp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Read clock in, one-cycle edge pulse out
  input wire logic rclk,
  output logic fall
);

  ddp_edge_state_t s_reg;
  ddp_edge_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.hist = {s_reg.hist[1:0], rclk};
    s_next.fall = (s_reg.hist == 3'h7) && !rclk; // RL22
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '{hist: 3'h0, fall: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign fall = s_reg.fall;

endmodule

// ### ddp_drive_model.sv
/*
  Behavioural drive beyond the port: read clock, inbound status lines
  and a monitor of the outbound cable.
  Assumes every signal is synchronous to the bench clock.
*/
module ddp_drive_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Request: strobe, error, done, ready, bad status par, bad data par
  input wire logic go,
  input wire logic [5:0] g_ctl,
  input wire logic [15:0] g_dat,
  // Inbound cable
  output logic rclk,
  output logic in_strobe,
  output logic in_error,
  output logic in_done,
  output logic in_ready,
  output logic stat_par,
  output logic [15:0] bus_in,
  output logic bus_in_par,
  // Outbound cable
  input wire logic wclk,
  input wire logic fstrobe,
  input wire logic [3:0] fcode,
  input wire logic fpar,
  input wire logic [15:0] bus_out,
  input wire logic bus_out_par,
  // Observations
  output logic [2:0] rph,
  output logic [7:0] got_n,
  output logic [7:0] got_bad,
  output logic [3:0] got_code,
  output logic [3:0] got_len,
  output logic [15:0] got_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic bad_s, bad_d, live, wclk_q, fs_q;
  logic [3:0] run;
  initial begin
    {rph, got_n, got_bad, got_code, got_len, got_data, run, bus_in} = '0;
    {in_strobe, in_error, in_done, in_ready, bad_s, bad_d, live, wclk_q, fs_q} = '0;
  end
  // Period of 8 clocks: the port samples once a clock, not every 8 ns
  assign rclk = ~rph[2];
  assign stat_par = ~(in_strobe ^ in_error ^ in_done ^ in_ready) ^ bad_s;
  assign bus_in_par = ~(^bus_in) ^ bad_d;
  always @(posedge clock) begin
    rph <= rst ? 3'd0 : rph + 3'd1;
    if (rph == 3'd7) begin
      {in_strobe, in_error, in_done} <= go ? g_ctl[5:3] : 3'b000;
      in_ready <= g_ctl[2];
      {bad_s, bad_d} <= go ? g_ctl[1:0] : 2'b00;
      // Idle data lines show the inverse of the last value
      bus_in <= (go && (g_ctl[5] || g_ctl[3])) ? g_dat : ~bus_in;
    end
    live <= ~rst;
    wclk_q <= wclk;
    fs_q <= fstrobe;
    run <= fstrobe ? run + 4'h1 : 4'h0;
    if (!fstrobe && run != 4'h0) begin
      got_len <= run;
      got_n <= got_n + 8'h01;
    end
    if (fstrobe && !wclk) begin
      got_code <= fcode;
      got_data <= bus_out;
    end
    // Bad parity, misaligned strobe or uneven clock count as faults
    if ((fstrobe && !wclk && !(^{fcode, fpar} && ^{bus_out, bus_out_par})) ||
        (live && !rst && (wclk == wclk_q || (fstrobe && !fs_q && wclk_q)))) begin
      got_bad <= got_bad + 8'h01;
    end
  end
endmodule

// ### test_disk_drive_port_status.sv
/*
  Self-checking bench of the drive port: functions, status reads,
  calls and inbound faults against the drive model.
  Assumes the package, ddp_port and ddp_drive_model are compiled first.
*/
module test_disk_drive_port_status;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] FC [13] = '{8'h00, 8'h01, 8'h0b, 8'h10, 8'h11, 8'h1c, 8'h23,
    8'h2f, 8'h3a, 8'h40, 8'h41, 8'h83, 8'hfb};
  localparam logic [3:0] FD [13] = '{4'hf, 4'he, 4'h1, 4'hc, 4'hb, 4'hd, 4'h7, 4'h8,
    4'h9, 4'h5, 4'h4, 4'h2, 4'h0};
  logic clock, rst, func_valid, call_pulse, int_enable, buf_a_perr, buf_b_perr, go;
  logic rclk, in_strobe, in_error, in_done, in_ready, stat_par, bus_in_par;
  logic wclk, fstrobe, fpar, bus_out_par, resp_valid, call_valid, rd_valid, wr_taken, wr_valid;
  logic [15:0] rd_data, wr_data;
  logic [7:0] func_code, got_n, got_bad;
  logic [15:0] func_param, bus_in, bus_out, resp_drive, resp_ctrl, call_data, got_data, g_dat;
  logic [3:0] fcode, got_code, got_len;
  logic [5:0] g_ctl;
  logic [2:0] rph;
  int mismatches, num_checks, cycles;

  ddp_port dut (.clock(clock), .rst(rst), .func_valid(func_valid), .func_code(func_code),
    .func_param(func_param), .call_pulse(call_pulse), .int_enable(int_enable),
    .buf_a_perr(buf_a_perr), .buf_b_perr(buf_b_perr), .wr_valid(wr_valid), .wr_data(wr_data),
    .rclk(rclk), .in_strobe(in_strobe), .in_error(in_error), .in_done(in_done),
    .in_ready(in_ready), .stat_par(stat_par), .bus_in(bus_in), .bus_in_par(bus_in_par),
    .wclk(wclk), .fstrobe(fstrobe), .fcode(fcode), .fpar(fpar), .bus_out(bus_out),
    .bus_out_par(bus_out_par), .resp_valid(resp_valid), .resp_drive(resp_drive),
    .resp_ctrl(resp_ctrl), .call_valid(call_valid), .call_data(call_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .wr_taken(wr_taken));
  ddp_drive_model drv (.clock(clock), .rst(rst), .go(go), .g_ctl(g_ctl), .g_dat(g_dat),
    .rclk(rclk), .in_strobe(in_strobe), .in_error(in_error), .in_done(in_done),
    .in_ready(in_ready), .stat_par(stat_par), .bus_in(bus_in), .bus_in_par(bus_in_par),
    .wclk(wclk), .fstrobe(fstrobe), .fcode(fcode), .fpar(fpar), .bus_out(bus_out),
    .bus_out_par(bus_out_par), .rph(rph), .got_n(got_n), .got_bad(got_bad),
    .got_code(got_code), .got_len(got_len), .got_data(got_data));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic sync6;
    do @(posedge clock); while (rph !== 3'd6);
  endtask
  task automatic issue(input logic [7:0] c, input logic [15:0] p);
    func_code <= c;
    func_param <= p;
    func_valid <= 1'b1;
    @(posedge clock);
    func_valid <= 1'b0;
  endtask
  // Drive answers in the read clock period after the next rise
  task automatic respond(input logic [5:0] c, input logic [15:0] d);
    sync6;
    g_ctl <= c;
    g_dat <= d;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
  endtask
  // Read placed after the flags of the last fall have settled
  task automatic rd_stat(input logic [15:0] ed, input logic [15:0] eb, input logic coin);
    logic [15:0] ec;
    int k;
    sync6;
    ec = eb | {8'h00, bus_in_par, stat_par, 5'h00, in_ready};
    buf_b_perr <= coin;
    issue(8'h30 | 8'($urandom % 8), 16'($urandom));
    buf_b_perr <= 1'b0;
    k = 0;
    while (resp_valid !== 1'b1 && k < 4) begin
      @(negedge clock);
      k++;
    end
    chk({15'h0000, resp_valid}, 16'h0001);
    chk(resp_drive, ed);
    chk(resp_ctrl, ec);
    @(posedge clock);
  endtask
  task automatic call_chk(input logic en, input logic [15:0] exp);
    int k;
    int_enable <= en;
    call_pulse <= 1'b1;
    @(posedge clock);
    call_pulse <= 1'b0;
    k = 0;
    while (call_valid !== 1'b1 && k < 3) begin
      @(negedge clock);
      k++;
    end
    chk({15'h0000, call_valid}, {15'h0000, en});
    if (en) chk(call_data, exp);
    @(posedge clock);
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, hang guard and main sequence
  // ----------------------------------------------------------------
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  initial begin
    logic [15:0] p, d;
    logic e, ld;
    logic [7:0] n0;
    int k;
    {clock, func_valid, call_pulse, int_enable, buf_a_perr, buf_b_perr, go, wr_valid} = '0;
    rst = 1'b1;
    func_code = 8'h00;
    {func_param, g_dat, wr_data} = '0;
    g_ctl = 6'b000100;
    p = 16'($urandom(42158));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rd_stat(16'h0000, 16'h0000, 1'b0);
    for (int i = 0; i < 13; i++) begin
      p = 16'($urandom);
      d = 16'($urandom);
      e = 1'($urandom % 2);
      n0 = got_n;
      issue(FC[i], p);
      @(posedge clock);
      issue(FC[i], 16'($urandom));
      @(posedge clock);
      k = 0;
      while (got_n == n0 && k < 20) begin
        @(posedge clock);
        k++;
      end
      chk({12'h000, got_code}, {12'h000, FD[i]});
      chk(got_data, p);
      chk({12'h000, got_len}, 16'h0002);
      chk({8'h00, got_bad}, 16'h0000);
      rd_stat(16'h0000, 16'h0100, 1'b0);
      respond({1'b1, e, 4'b1100}, d);
      call_chk(1'b1, p);
      call_chk(1'b0, p);
      chk({8'h00, got_n}, {8'h00, n0 + 8'h01});
      ld = FC[i][7:3] inside {5'h07, 5'h08, 5'h10, 5'h11, 5'h18, 5'h19, 5'h1f};
      rd_stat((ld && !e) ? p : d, e ? 16'h000c : 16'h0002, 1'b0);
      rd_stat(16'h0000, 16'h0000, 1'b0);
    end
    // Read takes a strobe-only parcel; write sends one data parcel
    for (int j = 0; j < 2; j++) begin
      p = 16'($urandom);
      d = 16'($urandom);
      n0 = got_n;
      wr_data <= d;
      wr_valid <= j[0];
      issue(j[0] ? 8'hc0 : 8'h80, p);
      k = 0;
      while (wr_taken !== j[0] && k < 20) begin
        @(posedge clock);
        k++;
      end
      wr_valid <= 1'b0;
      while (got_n == n0 && k < 20) begin
        @(posedge clock);
        k++;
      end
      chk({12'h000, got_code}, j[0] ? 16'h0003 : 16'h0002);
      chk({12'h000, got_len}, j[0] ? 16'h0004 : 16'h0002);
      chk(got_data, j[0] ? d : p);
      respond(6'b100100, d);
      k = 0;
      while (rd_valid !== 1'b1 && k < 8) begin
        @(posedge clock);
        k++;
      end
      chk({15'h0000, k < 8}, {15'h0000, !j[0]});
      if (!j[0]) chk(rd_data, d);
      respond(6'b001100, ~d);
      rd_stat(p, 16'h0000, 1'b0);
    end
    // A strobe without done loads the drive status from the cable
    d = 16'($urandom);
    respond(6'b100111, d);
    rd_stat(d, 16'h0030, 1'b0);
    d = ~d;
    respond(6'b100011, d);
    rd_stat(d, 16'h0000, 1'b0);
    respond(6'b000100, 16'h0000);
    buf_a_perr <= 1'b1;
    @(posedge clock);
    buf_a_perr <= 1'b0;
    buf_b_perr <= 1'b1;
    @(posedge clock);
    buf_b_perr <= 1'b0;
    rd_stat(16'h0000, 16'h0600, 1'b1);
    rd_stat(16'h0000, 16'h0400, 1'b0);
    tally_and_finish;
  end
endmodule
